/* File: inc/pct_pkg.sv */
// package of register offsets, fields, reset values and counts of the channel timebase
package pct_pkg;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_DUTY = 8'h04;
    localparam logic [7:0] OFF_PERIOD = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_UPDATE = 8'h10;
    localparam logic [7:0] OFF_ENABLE = 8'h14;
    localparam logic [7:0] OFF_DISABLE = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_FLAG = 8'h20;
    localparam logic [7:0] OFF_IRQ_EN = 8'h24;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
    localparam logic [7:0] OFF_DIV = 8'h2c;
    // ****************************************
    // mode register fields
    // ****************************************
    localparam int MODE_PRESCALE_LSB = 0;
    localparam int MODE_ALIGN_BIT = 8;
    localparam int MODE_LEVEL_BIT = 9;
    localparam int MODE_TARGET_BIT = 10;
    localparam logic [3:0] PRESCALE_MAX = 4'ha;
    localparam logic [3:0] SEL_CLK_A = 4'hb;
    localparam logic [3:0] SEL_CLK_B = 4'hc;
    // divider register: factor a in [7:0], factor b in [23:16]
    localparam int DIV_A_LSB = 0;
    localparam int DIV_B_LSB = 16;
    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int CNT_W = 16;
    localparam logic [10:0] MODE_RESET = 11'h000;
    localparam logic [15:0] DUTY_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
endpackage

/* File: src/pct_prescaler.sv */
// prescaler: master tick counter and the selectable divided tick enables
`timescale 1ns/1ns
`default_nettype none
module pct_prescaler (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // configuration
    input wire logic [3:0] prescale_select,
    input wire logic [7:0] divider_a_factor,
    input wire logic [7:0] divider_b_factor,
    // tick out
    output logic tick
);
    typedef struct packed {
        logic [9:0] mck_cnt;
        logic [7:0] cnt_a;
        logic [7:0] cnt_b;
        logic tick_a;
        logic tick_b;
    } pct_pre_t;

    pct_pre_t st, next_st;
    logic [10:0] wrap;

    // a power-of-two divisor ticks when bit k-1 falls, i.e. once every 2^k cycles
    always_comb begin
        next_st = st;
        wrap = {(st.mck_cnt & ~(st.mck_cnt + 10'h001)), 1'b1};
        next_st.mck_cnt = st.mck_cnt + 10'h001;
        next_st.tick_a = 1'b0;
        next_st.tick_b = 1'b0;
        if (divider_a_factor != 8'h00 && st.cnt_a + 8'h01 >= divider_a_factor) begin
            next_st.cnt_a = 8'h00;
            next_st.tick_a = 1'b1;
        end else begin
            next_st.cnt_a = st.cnt_a + 8'h01;
        end
        if (divider_b_factor != 8'h00 && st.cnt_b + 8'h01 >= divider_b_factor) begin
            next_st.cnt_b = 8'h00;
            next_st.tick_b = 1'b1;
        end else begin
            next_st.cnt_b = st.cnt_b + 8'h01;
        end
        if (prescale_select <= pct_pkg::PRESCALE_MAX) begin
            tick = wrap[prescale_select];
        end else if (prescale_select == pct_pkg::SEL_CLK_A) begin
            tick = st.tick_a;
        end else if (prescale_select == pct_pkg::SEL_CLK_B) begin
            tick = st.tick_b;
        end else begin
            tick = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* File: src/pct_counter.sv */
// channel counter: left or center aligned up/down count with period start marks
`timescale 1ns/1ns
`default_nettype none
module pct_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // control
    input wire logic tick,
    input wire logic restart,
    input wire logic alignment_select,
    input wire logic [15:0] period_value,
    // state
    output logic [15:0] channel_count,
    output logic counting_down,
    output logic period_start
);
    typedef struct packed {
        logic [15:0] cnt;
        logic down;
        logic start;
    } pct_cnt_t;

    pct_cnt_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        if (restart) begin
            next_st.cnt = 16'h0000;
            next_st.down = 1'b0;
            next_st.start = 1'b1;
        end else if (tick) begin
            if (!alignment_select) begin
                next_st.down = 1'b0;
                // wrap as the period value is reached, so a period is exactly period value ticks
                if ((st.cnt + 16'h0001) >= period_value) begin
                    next_st.cnt = 16'h0000;
                    next_st.start = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 16'h0001;
                end
            end else if (!st.down) begin
                // center: up to period then down to zero, twice as long
                if (st.cnt >= period_value) begin
                    next_st.down = 1'b1;
                    next_st.cnt = st.cnt - 16'h0001;
                end else begin
                    next_st.cnt = st.cnt + 16'h0001;
                end
            end else if (st.cnt <= 16'h0001) begin
                next_st.cnt = 16'h0000;
                next_st.down = 1'b0;
                next_st.start = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign channel_count = st.cnt;
    assign counting_down = st.down;
    assign period_start = st.start;
endmodule
`default_nettype wire

/* File: src/pct_channel.sv */
// top of one pwm channel timebase: register port, buffered update, output and flags
//
// Notes on behaviour
// - duty, period and update use only their low 16 bits.
// - left aligned prescaled: period is divisor times period value cycles.
// - center aligned: period is twice the left aligned figure.
// - divided clock a or b: period value times factor, doubled when centered.
// - enabling the channel clears its counter.
// - left aligned counter wraps to zero at the period value.
// - update register buffers writes so no glitched waveform appears.
// - at next period start update replaces duty (target 0) or period (1).
// - counter register is read only and shows the live count.
// - alignment select: 0 left aligned, 1 center aligned.
// - start level select: 0 starts low, 1 starts high.
// - enable write of 1 starts the channel, 0 has no effect.
// - period flag set per completed period, cleared by reading it; here the period start that follows an enable also sets it.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pct_channel (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // channel output and interrupt
    output logic pwm_out,
    output logic irq
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [3:0] prescale_select;
        logic alignment_select;
        logic start_level_select;
        logic update_target_select;
        logic [15:0] duty_value;
        logic [15:0] period_value;
        logic [15:0] update_value;
        logic update_pending;
        logic [7:0] divider_a_factor;
        logic [7:0] divider_b_factor;
        logic enabled;
        logic period_flag;
        logic irq_flag;
        logic irq_enable;
        logic restart;
        logic [31:0] rdata;
        logic out;
        logic irq_out;
    } pct_state_t;

    pct_state_t st, next_st;
    logic tick;
    logic [15:0] count;
    logic down;
    logic period_start;
    logic run_tick;
    logic active_level;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ****************************************
    // submodules
    // ****************************************
    pct_prescaler u_pre (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .prescale_select(st.prescale_select),
        .divider_a_factor(st.divider_a_factor),
        .divider_b_factor(st.divider_b_factor),
        .tick(tick)
    );

    // the counter stands still while the channel is off
    assign run_tick = tick & st.enabled;

    pct_counter u_cnt (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(run_tick),
        .restart(st.restart),
        .alignment_select(st.alignment_select),
        .period_value(st.period_value),
        .channel_count(count),
        .counting_down(down),
        .period_start(period_start)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.restart = 1'b0;
        active_level = 1'b0;
        // writes
        if (reg_wr) begin
            if (addr_is(reg_addr, pct_pkg::OFF_MODE)) begin
                next_st.prescale_select = reg_wdata[pct_pkg::MODE_PRESCALE_LSB +: 4];
                next_st.alignment_select = reg_wdata[pct_pkg::MODE_ALIGN_BIT];
                next_st.start_level_select = reg_wdata[pct_pkg::MODE_LEVEL_BIT];
                next_st.update_target_select = reg_wdata[pct_pkg::MODE_TARGET_BIT];
            end
            if (addr_is(reg_addr, pct_pkg::OFF_DUTY)) begin
                next_st.duty_value = reg_wdata[15:0];
            end
            if (addr_is(reg_addr, pct_pkg::OFF_PERIOD)) begin
                next_st.period_value = reg_wdata[15:0];
            end
            if (addr_is(reg_addr, pct_pkg::OFF_UPDATE)) begin
                next_st.update_value = reg_wdata[15:0];
                next_st.update_pending = 1'b1;
            end
            if (addr_is(reg_addr, pct_pkg::OFF_ENABLE) && reg_wdata[0]) begin
                next_st.enabled = 1'b1;
                next_st.restart = 1'b1;
            end
            if (addr_is(reg_addr, pct_pkg::OFF_DISABLE) && reg_wdata[0]) begin
                next_st.enabled = 1'b0;
            end
            if (addr_is(reg_addr, pct_pkg::OFF_IRQ_EN)) begin
                next_st.irq_enable = reg_wdata[0];
            end
            if (addr_is(reg_addr, pct_pkg::OFF_IRQ_CLR) && reg_wdata[0]) begin
                next_st.irq_flag = 1'b0;
            end
            if (addr_is(reg_addr, pct_pkg::OFF_DIV)) begin
                next_st.divider_a_factor = reg_wdata[pct_pkg::DIV_A_LSB +: 8];
                next_st.divider_b_factor = reg_wdata[pct_pkg::DIV_B_LSB +: 8];
            end
        end
        // reads: data in the following cycle only
        next_st.rdata = pct_pkg::READ_UNMAPPED;
        if (reg_rd) begin
            case (reg_addr)
                pct_pkg::OFF_MODE: begin
                    next_st.rdata = {21'h000000, st.update_target_select, st.start_level_select,
                                     st.alignment_select, 4'h0, st.prescale_select};
                end
                pct_pkg::OFF_DUTY: begin
                    next_st.rdata = {16'h0000, st.duty_value};
                end
                pct_pkg::OFF_PERIOD: begin
                    next_st.rdata = {16'h0000, st.period_value};
                end
                pct_pkg::OFF_COUNT: begin
                    next_st.rdata = {16'h0000, count};
                end
                pct_pkg::OFF_STATUS: begin
                    next_st.rdata = {31'h00000000, st.enabled};
                end
                pct_pkg::OFF_FLAG: begin
                    next_st.rdata = {31'h00000000, st.period_flag};
                    next_st.period_flag = 1'b0;
                end
                pct_pkg::OFF_IRQ_EN: begin
                    next_st.rdata = {31'h00000000, st.irq_enable};
                end
                pct_pkg::OFF_DIV: begin
                    next_st.rdata = {8'h00, st.divider_b_factor, 8'h00, st.divider_a_factor};
                end
                default: begin
                    next_st.rdata = pct_pkg::READ_UNMAPPED;
                end
            endcase
        end
        // period boundary: flags and buffered update; set wins over clear
        if (period_start && st.enabled) begin
            if (!st.restart) begin
                next_st.period_flag = 1'b1;
                next_st.irq_flag = 1'b1;
            end
            if (st.update_pending) begin
                // applied only at a boundary, so the running period is never cut
                if (st.update_target_select) begin
                    next_st.period_value = st.update_value;
                end else begin
                    next_st.duty_value = st.update_value;
                end
                next_st.update_pending = reg_wr && addr_is(reg_addr, pct_pkg::OFF_UPDATE);
            end
        end
        // waveform: start level until the duty value is reached
        if (st.alignment_select) begin
            active_level = (count >= st.duty_value) || down;
            if (down) begin
                active_level = count >= st.duty_value;
            end
        end else begin
            active_level = count >= st.duty_value;
        end
        if (st.enabled) begin
            next_st.out = active_level ? ~st.start_level_select : st.start_level_select;
        end else begin
            next_st.out = st.start_level_select;
        end
        next_st.irq_out = next_st.irq_flag & next_st.irq_enable;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0;
            st.duty_value <= pct_pkg::DUTY_RESET;
            st.period_value <= pct_pkg::PERIOD_RESET;
            st.divider_a_factor <= pct_pkg::DIV_RESET;
            st.divider_b_factor <= pct_pkg::DIV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign pwm_out = st.out;
    assign irq = st.irq_out;
endmodule
`default_nettype wire

/* File: verif/pct_channel_props.sv */
// concurrent checks on the ports of the channel timebase
`timescale 1ns/1ns
`default_nettype none
module pct_channel_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // outputs
    input wire logic pwm_out,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_upper_bits_zero: assert property (
        reg_rdata[31:16] == 16'h0000) else $error("read data upper half not zero");
    a_value_readback: assert property (
        reg_wr && (reg_addr == pct_pkg::OFF_DUTY || reg_addr == pct_pkg::OFF_PERIOD)
        ##2 reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3))
        else $error("duty or period readback differs");
    a_read_data_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h00000000) else $error("read data outside its cycle");
    a_update_reads_zero: assert property (
        reg_rd && reg_addr == pct_pkg::OFF_UPDATE |=> reg_rdata == 32'h00000000)
        else $error("update buffer readable");
    a_irq_mask_off: assert property (
        reg_wr && reg_addr == pct_pkg::OFF_IRQ_EN && !reg_wdata[0] |-> ##2 !irq) else $error("masked irq high");
    a_enable_sets_status: assert property (
        reg_wr && reg_addr == pct_pkg::OFF_ENABLE && reg_wdata[0] ##2 reg_rd && reg_addr == pct_pkg::OFF_STATUS
        |=> reg_rdata[0]) else $error("enable not in status");
    a_disable_clr_status: assert property (
        reg_wr && reg_addr == pct_pkg::OFF_DISABLE && reg_wdata[0] ##2 reg_rd && reg_addr == pct_pkg::OFF_STATUS
        |=> !reg_rdata[0]) else $error("disable not in status");
    a_enable_count_zero: assert property (
        reg_wr && reg_addr == pct_pkg::OFF_ENABLE && reg_wdata[0] ##3 reg_rd && reg_addr == pct_pkg::OFF_COUNT
        |=> reg_rdata == 32'h00000000) else $error("count not cleared by enable");
endmodule
bind pct_channel pct_channel_props u_props (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

/* File: verif/pct_load_model.sv */
// load model: measures period and high time of the channel waveform
`timescale 1ns/1ns
`default_nettype none
module pct_load_model (
    // clock
    input wire logic ref_clk,
    // waveform
    input wire logic pwm_out,
    // measurements, updated at each rising edge of the waveform
    output logic [31:0] meas_period,
    output logic [31:0] meas_high,
    output logic [31:0] rises
);
    logic prev = 1'b0;
    logic [31:0] cnt = 32'h0;
    logic [31:0] hcnt = 32'h0;
    initial begin
        meas_period = 32'h0;
        meas_high = 32'h0;
        rises = 32'h0;
    end
    // a passive load: it never drives anything back into the channel
    always @(posedge ref_clk) begin
        prev <= pwm_out;
        if (pwm_out && !prev) begin
            meas_period <= cnt;
            meas_high <= hcnt;
            rises <= rises + 32'h1;
            cnt <= 32'h1;
            hcnt <= 32'h1;
        end else begin
            cnt <= cnt + 32'h1;
            hcnt <= hcnt + {31'h0, pwm_out};
        end
    end
endmodule
`default_nettype wire

/* File: verif/pct_channel_tb.sv */
// self-checking bench of the channel timebase
`timescale 1ns/1ns
`default_nettype none
module pct_channel_tb;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic pwm_out;
    logic irq;
    logic [31:0] meas_period;
    logic [31:0] meas_high;
    logic [31:0] rises;
    logic [31:0] seed = 32'h00009535;
    logic [3:0] sel_tab [8] = '{4'h0, 4'h1, 4'h2, 4'hb, 4'hc, 4'h0, 4'h2, 4'hb};
    int num_errors = 0;
    int cmp_count = 0;
    pct_channel dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out), .irq(irq));
    pct_load_model load (.ref_clk(ref_clk), .pwm_out(pwm_out), .meas_period(meas_period),
        .meas_high(meas_high), .rises(rises));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd(input logic [31:0] n);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed % n;
    endfunction
    // cycles of n counts for the chosen clock source and alignment
    function automatic logic [31:0] cyc(input logic [3:0] s, input logic [7:0] fa, input logic [7:0] fb,
        input logic al, input logic [15:0] n);
        logic [31:0] dv;
        dv = (s == pct_pkg::SEL_CLK_A) ? {24'h0, fa} : (s == pct_pkg::SEL_CLK_B) ? {24'h0, fb} : 32'h1 << s;
        return dv * {16'h0, n} * (al ? 32'h2 : 32'h1);
    endfunction
    // cycles spent below the duty count: centered holds zero once and the rest twice
    function automatic logic [31:0] hcyc(input logic [3:0] s, input logic [7:0] fa, input logic [7:0] fb,
        input logic al, input logic [15:0] n);
        return al ? cyc(s, fa, fb, 1'b1, n) - cyc(s, fa, fb, 1'b0, 16'h1) : cyc(s, fa, fb, 1'b0, n);
    endfunction
    function automatic logic [31:0] mode(input logic [3:0] s, input logic al, input logic lv, input logic tg);
        return {21'h0, tg, lv, al, 4'h0, s};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_rises(input logic [31:0] n);
        logic [31:0] t;
        t = rises + n;
        for (int k = 0; k < 3000 && rises < t; k++) begin
            idle(1);
        end
        chk("rises", t, rises);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #500000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        logic [3:0] s;
        logic al;
        logic lv;
        logic [15:0] p;
        logic [15:0] d;
        logic [7:0] fa;
        logic [7:0] fb;
        logic [31:0] per;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        // reset values, write-only and unmapped places all read zero
        for (int i = 0; i < 14; i++) begin
            rdchk(8'(i * 4), pct_pkg::READ_UNMAPPED);
        end
        wr(pct_pkg::OFF_PERIOD, 32'habcd0009);
        rdchk(pct_pkg::OFF_PERIOD, 32'h00000009);
        wr(pct_pkg::OFF_COUNT, 32'h00001234);
        rdchk(pct_pkg::OFF_COUNT, 32'h00000000);
        wr(pct_pkg::OFF_ENABLE, 32'h00000000);
        rdchk(pct_pkg::OFF_STATUS, 32'h00000000);
        wr(pct_pkg::OFF_ENABLE, 32'h00000001);
        rdchk(pct_pkg::OFF_STATUS, 32'h00000001);
        fa = 8'(1 + rnd(3));
        fb = 8'(1 + rnd(3));
        wr(pct_pkg::OFF_DIV, {8'h0, fb, 8'h0, fa});
        for (int k = 0; k < 8; k++) begin
            s = sel_tab[k];
            // last pass left aligned, starting high: each rise then marks a period start
            al = (k == 7) ? 1'b0 : 1'(rnd(2));
            lv = (k == 7) ? 1'b1 : 1'(rnd(2));
            p = 16'(4 + rnd(7));
            d = 16'(1 + rnd(32'(p) - 1));
            wr(pct_pkg::OFF_DISABLE, 32'h1);
            wr(pct_pkg::OFF_MODE, mode(s, al, lv, 1'b0));
            wr(pct_pkg::OFF_PERIOD, {16'h0, p});
            wr(pct_pkg::OFF_DUTY, {16'h0, d});
            wr(pct_pkg::OFF_ENABLE, 32'h1);
            // early rises may come from the mode change and the partial first period
            wait_rises(4);
            per = cyc(s, fa, fb, al, p);
            chk("period", per, meas_period);
            chk("high", lv ? hcyc(s, fa, fb, al, d) : per - hcyc(s, fa, fb, al, d), meas_high);
        end
        // duty through the buffer: old value holds until the next period start
        wr(pct_pkg::OFF_UPDATE, {16'h0, (d == 16'h1) ? p - 16'h1 : 16'h1});
        wait_rises(1);
        chk("high", hcyc(s, fa, fb, al, d), meas_high);
        d = (d == 16'h1) ? p - 16'h1 : 16'h1;
        wait_rises(2);
        chk("high", hcyc(s, fa, fb, al, d), meas_high);
        wr(pct_pkg::OFF_MODE, mode(s, al, lv, 1'b1));
        wr(pct_pkg::OFF_UPDATE, {16'h0, p + 16'h3});
        wait_rises(1);
        chk("period", cyc(s, fa, fb, al, p), meas_period);
        wait_rises(2);
        chk("period", cyc(s, fa, fb, al, p + 16'h3), meas_period);
        // interrupt raised, masked, raised again, cleared
        wr(pct_pkg::OFF_IRQ_EN, 32'h1);
        wait_rises(1);
        idle(3);
        chk("irq", 32'h1, {31'h0, irq});
        wr(pct_pkg::OFF_IRQ_EN, 32'h0);
        idle(3);
        chk("irq", 32'h0, {31'h0, irq});
        wr(pct_pkg::OFF_IRQ_EN, 32'h1);
        idle(3);
        chk("irq", 32'h1, {31'h0, irq});
        wr(pct_pkg::OFF_DISABLE, 32'h1);
        rdchk(pct_pkg::OFF_STATUS, 32'h00000000);
        wr(pct_pkg::OFF_IRQ_CLR, 32'h1);
        idle(3);
        chk("irq", 32'h0, {31'h0, irq});
        rdchk(pct_pkg::OFF_FLAG, 32'h00000001);
        rdchk(pct_pkg::OFF_FLAG, 32'h00000000);
        // a stopped source keeps the restarted count at zero while it is read
        wr(pct_pkg::OFF_MODE, mode(4'hd, 1'b0, 1'b0, 1'b0));
        wr(pct_pkg::OFF_ENABLE, 32'h1);
        @(posedge ref_clk);
        rdchk(pct_pkg::OFF_COUNT, 32'h00000000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
